// ==== core/scc_pkg.sv ====
// Constants, timing figures and types shared by the chopper control block
package scc_pkg;

    // ============================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int BLANK_TIME_NS = 400;
    localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ============================================================
    // Chopping counter
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_START = 3'h0;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;

    // ============================================================
    // Serial frame layout (shared by normal data and table data)
    localparam int FRAME_W = 16;
    localparam int CODE_W = 4;
    localparam int CODE_LSB = 0;
    localparam int PHASE_BIT = 4;
    localparam int DSEL_LSB = 5;
    localparam int DSEL_W = 2;
    localparam logic [CODE_W-1:0] CODE_FULL = 4'hF;
    localparam logic [CODE_W-1:0] CODE_ZERO = 4'h0;

    // Table entry: [2:0] switch position, [3] enable; four entries
    localparam int ENTRY_W = 4;
    localparam int POS_W = 3;
    localparam int EN_BIT = 3;
    localparam logic [FRAME_W-1:0] TABLE_RST = 16'hEC80;

    // ============================================================
    // Bridge modes
    typedef enum logic [3:0] {
        SCC_OFF    = 4'h1,
        SCC_CHARGE = 4'h2,
        SCC_SLOW   = 4'h4,
        SCC_FAST   = 4'h8
    } scc_mode_e;

endpackage

// ==== core/scc_blank_filter.sv ====
// Comparator synchroniser and blanking filter
`timescale 1ns/1ps
module scc_blank_filter
    import scc_pkg::*;
#(
    parameter int BLANK = BLANK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic trip_in,
    output logic trip_q
);

    localparam int BW = $clog2(BLANK + 1);
    localparam logic [BW-1:0] BLANK_CNT = BW'(BLANK);

    logic meta_q;
    logic sync_q;
    logic [BW-1:0] cnt_q;

    always_ff @(posedge clk_sys) begin
        meta_q <= trip_in;
        sync_q <= meta_q;
    end

    // Only a trip held for the whole blank time gets through
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (!sync_q) begin
            cnt_q <= '0;
        end else if (cnt_q != BLANK_CNT) begin
            cnt_q <= cnt_q + BW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            trip_q <= 1'b0;
        end else begin
            trip_q <= sync_q && (cnt_q == BLANK_CNT);
        end
    end

    blank_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(trip_q) |-> $past(cnt_q) == BLANK_CNT)
        else $error("trip passed before blank time");

endmodule

// ==== core/scc_chopper.sv ====
// Chopping sequencer, serial data capture and output gating for one bridge
`timescale 1ns/1ps
module scc_chopper
    import scc_pkg::*;
#(
    parameter int BLANK = BLANK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic chop_ref_clock,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic strobe,
    input wire logic setup_sel,
    input wire logic current_over,
    input wire logic thermal_shutdown,
    input wire logic logic_supply_ok,
    input wire logic motor_supply_monitor,
    output logic upper1_q,
    output logic upper2_q,
    output logic lower1_q,
    output logic lower2_q,
    output logic [3:0] chop_mode_q,
    output logic [CNT_W-1:0] chop_count_q,
    output logic [CODE_W-1:0] current_set_q,
    output logic full_scale_q,
    output logic thermal_fault_q
);

    // ============================================================
    // Input synchronisers
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    logic [NSYNC-1:0] prev_q;

    assign pins = {motor_supply_monitor, logic_supply_ok, thermal_shutdown,
                   setup_sel, strobe, serial_data, serial_clock};

    // No reset here so a hot or dead-supply level is seen straight after reset
    always_ff @(posedge clk_sys) begin
        meta_q <= pins;
        sync_q <= meta_q;
        prev_q <= sync_q;
    end

    logic sclk_rise;
    logic strobe_rise;
    logic setup_rise;
    logic setup_fall;
    logic setup_s;
    logic sdata_s;
    logic hot_s;
    logic supply_ok_s;
    assign sclk_rise = sync_q[0] && !prev_q[0];
    assign sdata_s = sync_q[1];
    assign strobe_rise = sync_q[2] && !prev_q[2];
    assign setup_s = sync_q[3];
    assign setup_rise = sync_q[3] && !prev_q[3];
    assign setup_fall = !sync_q[3] && prev_q[3];
    assign hot_s = sync_q[4];
    assign supply_ok_s = sync_q[5] && sync_q[6];

    // Reference clock edge finder, same two-stage pattern
    logic ref_meta_q;
    logic ref_sync_q;
    logic ref_prev_q;
    logic ref_rise;
    always_ff @(posedge clk_sys) begin
        ref_meta_q <= chop_ref_clock;
        ref_sync_q <= ref_meta_q;
        ref_prev_q <= ref_sync_q;
    end
    assign ref_rise = ref_sync_q && !ref_prev_q;

    logic over_q;
    scc_blank_filter #(.BLANK(BLANK)) u_blank (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .trip_in(current_over),
        .trip_q(over_q)
    );

    // ============================================================
    // Serial shift register, table and latched data
    logic [FRAME_W-1:0] shift_q;
    logic [FRAME_W-1:0] table_q;
    logic phase_q;
    logic [DSEL_W-1:0] dsel_q;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            shift_q <= '0;
        end else if (setup_rise) begin
            shift_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[FRAME_W-2:0], sdata_s};
        end
    end

    // Every reset reloads the default profile; host tables must be loaded again
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            table_q <= TABLE_RST;
        end else if (setup_fall) begin
            table_q <= shift_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            current_set_q <= CODE_ZERO;
            full_scale_q <= 1'b0;
            phase_q <= 1'b0;
            dsel_q <= '0;
        end else if (strobe_rise && !setup_s) begin
            current_set_q <= shift_q[CODE_LSB +: CODE_W];
            full_scale_q <= shift_q[CODE_LSB +: CODE_W] == CODE_FULL;
            phase_q <= shift_q[PHASE_BIT];
            dsel_q <= shift_q[DSEL_LSB +: DSEL_W];
        end
    end

    logic [ENTRY_W-1:0] entry;
    logic [POS_W-1:0] switch_pos;
    logic mixed_en;
    assign entry = table_q[dsel_q * ENTRY_W +: ENTRY_W];
    assign switch_pos = entry[POS_W-1:0];
    assign mixed_en = entry[EN_BIT];

    // ============================================================
    // Chopping counter with strobe restart
    logic restart_q;
    logic wrap;
    assign wrap = ref_rise && (restart_q || chop_count_q == CNT_LAST);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            restart_q <= 1'b0;
        end else if (strobe_rise && !setup_s) begin
            restart_q <= 1'b1;
        end else if (ref_rise) begin
            restart_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            chop_count_q <= CNT_START;
        end else if (wrap) begin
            chop_count_q <= CNT_START;
        end else if (ref_rise) begin
            chop_count_q <= chop_count_q + CNT_W'(1);
        end
    end

    // ============================================================
    // Mode sequencer
    scc_mode_e mode_q;
    scc_mode_e mode_d;
    logic [CNT_W-1:0] next_count;
    assign next_count = chop_count_q + CNT_W'(1);

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            SCC_OFF: begin
                mode_d = SCC_CHARGE;
            end
            SCC_CHARGE: begin
                if (over_q) begin
                    mode_d = SCC_SLOW;
                end
            end
            SCC_SLOW: begin
                if (mixed_en && ref_rise && next_count == switch_pos) begin
                    mode_d = SCC_FAST;
                end
            end
            SCC_FAST: begin
                mode_d = SCC_FAST;
            end
            default: begin
                mode_d = SCC_OFF;
            end
        endcase
        if (wrap) begin
            // Strobe restart always passes through charge; comparison decides after
            // Overcurrent at the end of a fast phase drops only the next charge
            if (restart_q || !(over_q && mode_q == SCC_FAST)) begin
                mode_d = SCC_CHARGE;
            end else if (mixed_en && switch_pos == CNT_START) begin
                mode_d = SCC_FAST;
            end else begin
                mode_d = SCC_SLOW;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mode_q <= SCC_OFF;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ============================================================
    // Protection and bridge drive
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            thermal_fault_q <= 1'b0;
        end else if (hot_s) begin
            thermal_fault_q <= 1'b1;
        end
    end

    logic drive_ok;
    assign drive_ok = supply_ok_s && !thermal_fault_q && !hot_s && current_set_q != CODE_ZERO;

    always_ff @(posedge clk_sys) begin
        if (!reset_n || !drive_ok) begin
            {upper1_q, upper2_q, lower1_q, lower2_q} <= 4'h0;
        end else begin
            case (mode_q)
                SCC_CHARGE: begin
                    {upper1_q, upper2_q, lower1_q, lower2_q} <= phase_q ? 4'h9 : 4'h6;
                end
                SCC_SLOW: begin
                    {upper1_q, upper2_q, lower1_q, lower2_q} <= 4'h3;
                end
                SCC_FAST: begin
                    {upper1_q, upper2_q, lower1_q, lower2_q} <= phase_q ? 4'h6 : 4'h9;
                end
                default: begin
                    {upper1_q, upper2_q, lower1_q, lower2_q} <= 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            chop_mode_q <= SCC_OFF;
        end else begin
            chop_mode_q <= mode_q;
        end
    end

    // ============================================================
    // Checks
    strobe_restart_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        restart_q && ref_rise |=> chop_count_q == CNT_START && mode_q == SCC_CHARGE)
        else $error("strobe restart missed");
    restart_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(restart_q) |-> ##[1:12] !restart_q)
        else $error("restart held past one reference cycle");
    count_wrap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ref_rise && chop_count_q == CNT_LAST |=> chop_count_q == CNT_START)
        else $error("counter did not wrap at seven");
    count_step_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ref_rise && !restart_q && chop_count_q != CNT_LAST
        |=> chop_count_q == $past(chop_count_q) + CNT_W'(1))
        else $error("counter did not step on reference edge");
    reset_off_a: assert property (@(posedge clk_sys)
        !reset_n |=> !upper1_q && !upper2_q && !lower1_q && !lower2_q
            && chop_count_q == CNT_START)
        else $error("outputs or counter active in reset");
    supply_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !supply_ok_s |=> {upper1_q, upper2_q, lower1_q, lower2_q} == 4'h0)
        else $error("bridge driven with supply low");
    thermal_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        thermal_fault_q |=> thermal_fault_q && !upper1_q && !upper2_q)
        else $error("thermal fault cleared without reset");
    table_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        setup_fall |=> table_q == $past(shift_q))
        else $error("table not stored on setup release");
    code_latch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        strobe_rise && !setup_s |=> current_set_q == $past(shift_q[CODE_W-1:0])
            && full_scale_q == ($past(shift_q[CODE_W-1:0]) == CODE_FULL))
        else $error("current code not latched on strobe");
    pure_slow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mode_q == SCC_SLOW && !mixed_en && !wrap |=> mode_q == SCC_SLOW)
        else $error("fast decay with switch point disabled");
    mixed_switch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mode_q == SCC_SLOW && mixed_en && ref_rise && !wrap && next_count == switch_pos
        |=> mode_q == SCC_FAST)
        else $error("missed slow to fast switch point");
    charge_cancel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wrap && !restart_q && over_q && mode_q == SCC_FAST |=> mode_q != SCC_CHARGE)
        else $error("charge not cancelled after overcurrent");

endmodule

// ==== verif/scc_host.sv ====
// Host controller model driving the serial, strobe and setup pins
`timescale 1ns/1ps
module scc_host (
    input wire logic clk_sys,
    output logic serial_clock,
    output logic serial_data,
    output logic strobe,
    output logic setup_sel
);
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        strobe = 1'b0;
        setup_sel = 1'b0;
    end

    // ============================================================
    // Pin timing
    // Four cycles per level keeps clear of the three-cycle minimum
    task automatic hold();
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic send(input logic [15:0] f);
        for (int i = 15; i >= 0; i--) begin
            serial_data <= f[i];
            hold();
            serial_clock <= 1'b1;
            hold();
            serial_clock <= 1'b0;
        end
        hold();
        // Stale data would hide a late sample
        serial_data <= ~serial_data;
    endtask

    task automatic pulse_strobe();
        strobe <= 1'b1;
        hold();
        strobe <= 1'b0;
        hold();
    endtask

    task automatic load_table(input logic [15:0] f);
        @(posedge clk_sys);
        setup_sel <= 1'b1;
        hold();
        send(f);
        setup_sel <= 1'b0;
        hold();
    endtask
endmodule

// ==== verif/scc_chopper_test.sv ====
// Self-checking bench for the chopper control block
`timescale 1ns/1ps
module scc_chopper_test;
    import scc_pkg::*;
    localparam int POS = 3;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic chop_ref_clock = 1'b0;
    logic current_over = 1'b0;
    logic thermal_shutdown = 1'b0;
    logic logic_supply_ok = 1'b1;
    logic motor_supply_monitor = 1'b1;
    logic serial_clock, serial_data, strobe, setup_sel;
    logic upper1_q, upper2_q, lower1_q, lower2_q, full_scale_q, thermal_fault_q;
    logic [3:0] chop_mode_q;
    logic [CNT_W-1:0] chop_count_q;
    logic [CODE_W-1:0] current_set_q;
    logic [3:0] gates;
    logic [3:0] code;
    int m_cnt = 0;
    int mode_pos = -1;
    bit pend = 1'b0;
    bit seen_charge = 1'b0;
    bit seen_slow = 1'b0;
    int errors = 0;
    int n_checks = 0;

    always #10 clk_sys = ~clk_sys;
    initial begin
        // First reference edge falls after reset release, so model and counter agree
        #87;
        forever #80 chop_ref_clock = ~chop_ref_clock;
    end
    assign gates = {upper1_q, upper2_q, lower1_q, lower2_q};

    scc_host u_host (.clk_sys(clk_sys), .serial_clock(serial_clock),
        .serial_data(serial_data), .strobe(strobe), .setup_sel(setup_sel));

    scc_chopper #(.BLANK(4)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .chop_ref_clock(chop_ref_clock), .serial_clock(serial_clock),
        .serial_data(serial_data), .strobe(strobe), .setup_sel(setup_sel),
        .current_over(current_over), .thermal_shutdown(thermal_shutdown),
        .logic_supply_ok(logic_supply_ok), .motor_supply_monitor(motor_supply_monitor),
        .upper1_q(upper1_q), .upper2_q(upper2_q), .lower1_q(lower1_q), .lower2_q(lower2_q),
        .chop_mode_q(chop_mode_q), .chop_count_q(chop_count_q),
        .current_set_q(current_set_q), .full_scale_q(full_scale_q),
        .thermal_fault_q(thermal_fault_q));

    // ============================================================
    // Checking helpers
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wait_cnt(input int v);
        int k;
        k = 0;
        while (m_cnt != v && k < 100) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 100) begin
            errors++;
            test_done();
        end
    endtask

    // Strobe lands early in a period so its restart hits the next reference edge
    task automatic restart();
        @(posedge chop_ref_clock);
        @(posedge clk_sys);
        pend = 1'b1;
        u_host.pulse_strobe();
    endtask

    task automatic frame(input logic [3:0] c, input logic [1:0] ds);
        u_host.send({9'h000, ds, 1'b1, c});
        restart();
    endtask

    // ============================================================
    // Reference model of the chopping counter and decay sequence
    always @(posedge chop_ref_clock) begin
        if (!reset_n)
            m_cnt = 0;
        else if (pend) begin
            m_cnt = 0;
            pend = 1'b0;
        end else
            m_cnt = (m_cnt + 1) % 8;
        repeat (6) @(posedge clk_sys);
        if (reset_n) begin
            chk(16'(m_cnt), 16'(chop_count_q));
            if (mode_pos >= 0)
                chk(m_cnt >= mode_pos ? SCC_FAST : SCC_SLOW, chop_mode_q);
        end
    end

    always @(posedge clk_sys) begin
        if (chop_mode_q === SCC_CHARGE)
            seen_charge = 1'b1;
        if (chop_mode_q === SCC_SLOW)
            seen_slow = 1'b1;
    end

    // ============================================================
    // Main sequence
    initial begin
        void'($urandom(71));
        repeat (5) @(posedge clk_sys);
        chk(16'h0000, 16'(gates));
        chk(16'(CNT_START), 16'(chop_count_q));
        chk(SCC_OFF, chop_mode_q);
        reset_n <= 1'b1;
        repeat (10) @(posedge chop_ref_clock);
        // Entry 3 fast from position 3, entry 1 from 2, others pure slow
        u_host.load_table(16'hB5A3);
        for (int i = 0; i < 6; i++) begin
            code = (i == 0) ? CODE_FULL : 4'($urandom % 16);
            frame(code, 2'h3);
            chk(16'(code), 16'(current_set_q));
            chk(16'(code == CODE_FULL), 16'(full_scale_q));
        end
        frame(CODE_FULL, 2'h3);
        repeat (2) @(posedge chop_ref_clock);
        chk(SCC_CHARGE, chop_mode_q);
        chk(16'h0009, 16'(gates));
        @(posedge clk_sys);
        seen_slow = 1'b0;
        current_over <= 1'b1;
        repeat (2) @(posedge clk_sys);
        current_over <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(SCC_CHARGE, chop_mode_q);
        chk(16'h0000, 16'(seen_slow));
        for (int k = 0; k < 2; k++) begin
            if (k == 0)
                logic_supply_ok <= 1'b0;
            else
                motor_supply_monitor <= 1'b0;
            repeat (8) @(posedge clk_sys);
            chk(16'h0000, 16'(gates));
            logic_supply_ok <= 1'b1;
            motor_supply_monitor <= 1'b1;
            repeat (8) @(posedge clk_sys);
            chk(16'h0009, 16'(gates));
        end
        current_over <= 1'b1;
        repeat (9) @(posedge chop_ref_clock);
        mode_pos = POS;
        seen_charge = 1'b0;
        repeat (16) @(posedge chop_ref_clock);
        chk(16'h0000, 16'(seen_charge));
        mode_pos = -1;
        for (int k = 0; k < 2; k++) begin
            wait_cnt(k == 0 ? 0 : 4);
            seen_charge = 1'b0;
            restart();
            repeat (12) @(posedge clk_sys);
            chk(16'h0001, 16'(seen_charge));
        end
        // Disabled switch point: each period charges, then stays slow to its end
        frame(CODE_FULL, 2'h0);
        seen_charge = 1'b0;
        mode_pos = 8;
        repeat (4) @(posedge chop_ref_clock);
        mode_pos = -1;
        chk(16'h0001, 16'(seen_charge));
        @(posedge clk_sys);
        current_over <= 1'b0;
        thermal_shutdown <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(16'h0001, 16'(thermal_fault_q));
        chk(16'h0000, 16'(gates));
        thermal_shutdown <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(16'h0000, 16'(gates));
        // Reset spans one reference edge and releases well after it
        @(posedge chop_ref_clock);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (12) @(posedge clk_sys);
        chk(16'(CNT_START), 16'(chop_count_q));
        chk(16'h0000, 16'(gates));
        reset_n <= 1'b1;
        frame(CODE_FULL, 2'h3);
        repeat (20) @(posedge clk_sys);
        chk(16'h0000, 16'(thermal_fault_q));
        chk(16'h0009, 16'(gates));
        test_done();
    end
endmodule
